// ==== logic/bcu_map.svh ====
/*
 * Constants of the BCD add, subtract and complement unit: widths, limits,
 * reset values and arithmetic adjust figures.
 * Assumes it is included by its bare name from logic/ sources.
 */
`ifndef BCU_MAP_SVH
`define BCU_MAP_SVH

`define BCU_WORD_W      16
`define BCU_FUNC_W      6
`define BCU_ADDR_W      9
`define BCU_MEM_DEPTH   512
`define BCU_DIGITS      4
`define BCU_OPNDS       3
`define BCU_PTR_MAX     16'h0511
`define BCU_DIGIT_MAX   5'h09
`define BCU_ADD_ADJ     5'h06
`define BCU_SUB_ADJ     5'h0a
`define BCU_FLAG_RST    1'b0
`define BCU_WORD_RST    16'h0000
`define BCU_ZERO_WORD   16'h0000
`define BCU_IDX_SRC1    2'h0
`define BCU_IDX_SRC2    2'h1
`define BCU_IDX_DST     2'h2

`endif

// ==== logic/bcu_pkg.sv ====
/*
 * Types of the BCD add, subtract and complement unit.
 * Assumes bcu_map.svh is on the include path.
 */
`include "bcu_map.svh"

package bcu_pkg;

	typedef enum logic [`BCU_FUNC_W-1:0] {
		FN_BIT_INVERT = 6'h1d,
		FN_BCD_ADD    = 6'h1e,
		FN_BCD_SUB    = 6'h1f
	} bcu_func_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_FETCH = 3'b010,
		ST_WAIT  = 3'b011,
		ST_EXEC  = 3'b100
	} bcu_state_type;

endpackage : bcu_pkg

// ==== logic/bcu_unit.sv ====
/*
 * Word-operation datapath: bit inversion, 4-digit BCD addition and 4-digit
 * BCD subtraction, with indirect operands resolved through the word memory
 * area and the carry, zero and error flags.
 * Assumes the instruction sequencer on the same clock presents one request
 * at a time, holding it until req_ready, and drives carry_clear_op as the
 * carry-clear instruction.
 */
`timescale 1ns/100ps
`default_nettype none
`include "bcu_map.svh"

module bcu_unit
	import bcu_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   req_valid,
	output logic                        req_ready,
	input  wire logic [`BCU_FUNC_W-1:0] function_code,
	input  wire logic                   acc_bit,
	input  wire logic [`BCU_WORD_W-1:0] src1_word,
	input  wire logic                   src1_ind,
	input  wire logic [`BCU_WORD_W-1:0] src2_word,
	input  wire logic                   src2_ind,
	input  wire logic [`BCU_WORD_W-1:0] dst_word,
	input  wire logic                   dst_ind,
	input  wire logic                   carry_clear_op,
	input  wire logic                   error_clear,
	output logic      [`BCU_WORD_W-1:0] res_word,
	output logic                        res_write,
	output logic                        done,
	output logic                        skipped,
	output logic                        carry_flag,
	output logic                        zero_flag,
	output logic                        error_flag,
	input  wire logic                   host_mem_we,
	input  wire logic [`BCU_ADDR_W-1:0] host_mem_addr,
	input  wire logic [`BCU_WORD_W-1:0] host_mem_wdata,
	output logic      [`BCU_WORD_W-1:0] host_mem_rdata
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	function automatic logic is_bcd(input logic [`BCU_WORD_W-1:0] w);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < `BCU_DIGITS; i++) begin
			if ({1'b0, w[4*i +: 4]} > `BCU_DIGIT_MAX) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : is_bcd

	// Only meaningful once is_bcd holds and the value is in range.
	function automatic logic [`BCU_ADDR_W-1:0] ptr_addr(input logic [`BCU_WORD_W-1:0] w);
		logic [11:0] bin;
		bin = 12'(w[11:8]) * 12'h064 + 12'(w[7:4]) * 12'h00a + 12'(w[3:0]);
		return bin[`BCU_ADDR_W-1:0];
	endfunction : ptr_addr

	// ------------------------------------------------------------------
	// Request, flag and operand state
	// ------------------------------------------------------------------

	bcu_state_type          state_q,   state_d;
	bcu_func_type           func_q,    func_d;
	logic [`BCU_WORD_W-1:0] opnd_q [0:`BCU_OPNDS-1];
	logic [`BCU_WORD_W-1:0] opnd_d [0:`BCU_OPNDS-1];
	logic [`BCU_OPNDS-1:0]  ind_q,     ind_d;
	logic [1:0]             idx_q,     idx_d;
	logic                   carry_q,   carry_d;
	logic                   zero_q,    zero_d;
	logic                   error_q,   error_d;
	logic [`BCU_WORD_W-1:0] res_q,     res_d;
	logic                   resw_q,    resw_d;
	logic                   done_q,    done_d;
	logic                   skip_q,    skip_d;
	logic [`BCU_ADDR_W-1:0] dptr_q,    dptr_d;

	logic                   mem_we;
	logic [`BCU_ADDR_W-1:0] mem_waddr;
	logic [`BCU_WORD_W-1:0] mem_wdata;
	logic [`BCU_ADDR_W-1:0] mem_raddr;
	logic [`BCU_WORD_W-1:0] mem_rdata;

	// ------------------------------------------------------------------
	// BCD digit arithmetic
	// ------------------------------------------------------------------

	logic [`BCU_DIGITS:0]   add_c;
	logic [`BCU_DIGITS:0]   sub_b;
	logic [`BCU_WORD_W-1:0] add_sum;
	logic [`BCU_WORD_W-1:0] sub_dif;
	logic [`BCU_WORD_W-1:0] inv_word;

	assign add_c[0] = carry_q;
	assign sub_b[0] = carry_q;
	assign inv_word = ~opnd_q[`BCU_IDX_DST];

	// Digit 0 sits in the low nibble, so the chain runs upward.
	for (genvar g = 0; g < `BCU_DIGITS; g++) begin : g_digit
		logic [4:0] a5;
		logic [4:0] b5;
		logic [4:0] s5;
		logic [4:0] d5;
		logic       ov;
		assign a5 = {1'b0, opnd_q[`BCU_IDX_SRC1][4*g +: 4]};
		assign b5 = {1'b0, opnd_q[`BCU_IDX_SRC2][4*g +: 4]};
		assign s5 = a5 + b5 + {4'h0, add_c[g]};
		assign ov = s5 > `BCU_DIGIT_MAX;
		assign add_c[g+1] = ov;
		assign add_sum[4*g +: 4] = ov ? 4'(s5 + `BCU_ADD_ADJ) : s5[3:0];
		assign d5 = a5 - b5 - {4'h0, sub_b[g]};
		assign sub_b[g+1] = d5[4];
		// Wrapping each negative digit by ten leaves the tens complement.
		assign sub_dif[4*g +: 4] = d5[4] ? 4'(d5 + `BCU_SUB_ADJ) : d5[3:0];
	end

	// ------------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------------

	logic                   needs_src;
	logic                   needs_dst_rd;
	logic                   ptr_bad;
	logic                   opnd_bad;
	logic [`BCU_WORD_W-1:0] result;
	logic                   res_carry;

	assign req_ready = (state_q == ST_IDLE);

	always_comb begin
		needs_src    = (func_q == FN_BCD_ADD) || (func_q == FN_BCD_SUB);
		needs_dst_rd = (func_q == FN_BIT_INVERT);
		ptr_bad      = 1'b0;
		for (int i = 0; i < `BCU_OPNDS; i++) begin
			if (ind_q[i] && (i == `BCU_IDX_DST || needs_src)
				&& (!is_bcd(opnd_q[i]) || opnd_q[i] > `BCU_PTR_MAX)) begin
				ptr_bad = 1'b1;
			end
		end
		// Source constants and fetched source words alike must be 0000..9999; the destination word is not checked.
		opnd_bad = !is_bcd(opnd_q[`BCU_IDX_SRC1])
			|| !is_bcd(opnd_q[`BCU_IDX_SRC2]);
		case (func_q)
			FN_BCD_ADD: begin
				result    = add_sum;
				res_carry = add_c[`BCU_DIGITS];
			end
			FN_BCD_SUB: begin
				result    = sub_dif;
				res_carry = sub_b[`BCU_DIGITS];
			end
			default: begin
				result    = inv_word;
				res_carry = carry_q;
			end
		endcase
	end

	always_comb begin
		state_d   = state_q;
		func_d    = func_q;
		opnd_d    = opnd_q;
		ind_d     = ind_q;
		idx_d     = idx_q;
		carry_d   = carry_q;
		zero_d    = zero_q;
		error_d   = error_q;
		res_d     = res_q;
		resw_d    = 1'b0;
		done_d    = 1'b0;
		skip_d    = 1'b0;
		dptr_d    = dptr_q;
		mem_we    = host_mem_we && (state_q == ST_IDLE);
		mem_waddr = host_mem_addr;
		mem_wdata = host_mem_wdata;
		mem_raddr = host_mem_addr;
		if (carry_clear_op) begin
			carry_d = `BCU_FLAG_RST;
		end
		if (error_clear) begin
			error_d = `BCU_FLAG_RST;
		end
		case (state_q)
			ST_IDLE: begin
				if (req_valid) begin
					if (!acc_bit || !(function_code inside
						{FN_BIT_INVERT, FN_BCD_ADD, FN_BCD_SUB})) begin
						done_d = 1'b1;
						skip_d = 1'b1;
					end else begin
						func_d  = bcu_func_type'(function_code);
						opnd_d  = '{src1_word, src2_word, dst_word};
						ind_d   = {dst_ind, src2_ind, src1_ind};
						idx_d   = `BCU_IDX_SRC1;
						// A destination fetch overwrites its slot, so the address is kept here.
						dptr_d  = ptr_addr(dst_word);
						state_d = ST_CHECK;
					end
				end
			end
			ST_CHECK: begin
				if (ptr_bad) begin
					error_d = 1'b1;
					done_d  = 1'b1;
					skip_d  = 1'b1;
					state_d = ST_IDLE;
				end else begin
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				mem_raddr = ptr_addr(opnd_q[idx_q]);
				if (ind_q[idx_q] && (idx_q == `BCU_IDX_DST ? needs_dst_rd : needs_src)) begin
					state_d = ST_WAIT;
				end else if (idx_q == `BCU_IDX_DST) begin
					state_d = ST_EXEC;
				end else begin
					idx_d = idx_q + 2'h1;
				end
			end
			ST_WAIT: begin
				// The pointer stays in the operand slot until the data land.
				mem_raddr     = ptr_addr(opnd_q[idx_q]);
				opnd_d[idx_q] = mem_rdata;
				if (idx_q == `BCU_IDX_DST) begin
					state_d = ST_EXEC;
				end else begin
					idx_d   = idx_q + 2'h1;
					state_d = ST_FETCH;
				end
			end
			ST_EXEC: begin
				done_d  = 1'b1;
				state_d = ST_IDLE;
				if (needs_src && opnd_bad) begin
					error_d = 1'b1;
					skip_d  = 1'b1;
				end else begin
					zero_d  = (result == `BCU_ZERO_WORD);
					carry_d = res_carry;
					res_d   = result;
					if (ind_q[`BCU_IDX_DST]) begin
						mem_we    = 1'b1;
						mem_waddr = dptr_q;
						mem_wdata = result;
					end else begin
						resw_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			func_q  <= FN_BIT_INVERT;
			opnd_q  <= '{`BCU_WORD_RST, `BCU_WORD_RST, `BCU_WORD_RST};
			ind_q   <= '0;
			idx_q   <= `BCU_IDX_SRC1;
			carry_q <= `BCU_FLAG_RST;
			zero_q  <= `BCU_FLAG_RST;
			error_q <= `BCU_FLAG_RST;
			res_q   <= `BCU_WORD_RST;
			resw_q  <= 1'b0;
			done_q  <= 1'b0;
			skip_q  <= 1'b0;
			dptr_q  <= '0;
		end else begin
			state_q <= state_d;
			func_q  <= func_d;
			opnd_q  <= opnd_d;
			ind_q   <= ind_d;
			idx_q   <= idx_d;
			carry_q <= carry_d;
			zero_q  <= zero_d;
			error_q <= error_d;
			res_q   <= res_d;
			resw_q  <= resw_d;
			done_q  <= done_d;
			skip_q  <= skip_d;
			dptr_q  <= dptr_d;
		end
	end

	// ------------------------------------------------------------------
	// Word memory area and outputs
	// ------------------------------------------------------------------

	bcu_word_mem u_mem (
		.clk     (clk),
		.wr_en   (mem_we),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);

	assign host_mem_rdata = mem_rdata;
	assign res_word       = res_q;
	assign res_write      = resw_q;
	assign done           = done_q;
	assign skipped        = skip_q;
	assign carry_flag     = carry_q;
	assign zero_flag      = zero_q;
	assign error_flag     = error_q;

endmodule : bcu_unit

`default_nettype wire

// ==== logic/bcu_word_mem.sv ====
/*
 * Word memory area: 512 words of 16 bits, one write port, one read port
 * whose data come out of a register one clock after the address.
 * Assumes a single clock; contents are not reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "bcu_map.svh"

module bcu_word_mem (
	input  wire logic                   clk,
	input  wire logic                   wr_en,
	input  wire logic [`BCU_ADDR_W-1:0] wr_addr,
	input  wire logic [`BCU_WORD_W-1:0] wr_data,
	input  wire logic [`BCU_ADDR_W-1:0] rd_addr,
	output logic      [`BCU_WORD_W-1:0] rd_data
);

	logic [`BCU_WORD_W-1:0] mem_q [0:`BCU_MEM_DEPTH-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		rd_data <= mem_q[rd_addr];
	end

endmodule : bcu_word_mem

`default_nettype wire

// ==== testbench/bcd_add_sub_complement_unit_bench.sv ====
/* Self-checking bench of the word unit.
 * Assumes the unit, its package, the checker and sequencer model. */
`timescale 1ns/100ps
`default_nettype none

module bcd_add_sub_complement_unit_bench import bcu_pkg::*;;
	logic        clk, sys_rst, start, acc_bit, src1_ind, src2_ind, dst_ind;
	logic        carry_clear_op, error_clear, host_mem_we, req_valid, req_ready;
	logic        res_write, done, skipped, carry_flag, zero_flag, error_flag;
	logic [5:0]  function_code;
	logic [8:0]  host_mem_addr;
	logic [15:0] src1_word, src2_word, dst_word, host_mem_wdata, host_mem_rdata;
	logic [15:0] res_word, stored;
	int          n_fail, cmp_count, cyc;

	bcu_unit      i_dut (.*);
	bcu_seq_model i_seq (.*);

	// ------
	// Helpers
	// ------
	function automatic logic [18:0] st();
		return {stored, carry_flag, zero_flag, error_flag};
	endfunction : st

	task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic op(input logic [5:0] fc, input logic ac, input logic [15:0] a, b, d,
			input logic [2:0] ind);
		int n;
		@(posedge clk);
		{function_code, acc_bit, src1_word, src2_word, dst_word} <= {fc, ac, a, b, d};
		{src1_ind, src2_ind, dst_ind} <= ind;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 40) begin
			n_fail++;
		end
		// The model stores the result one edge after the pulse.
		@(posedge clk);
		#1;
	endtask : op

	task automatic pl(input logic c, input logic e);
		@(posedge clk);
		{carry_clear_op, error_clear} <= {c, e};
		@(posedge clk);
		{carry_clear_op, error_clear} <= 2'b00;
	endtask : pl

	task automatic mw(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk);
		{host_mem_we, host_mem_addr, host_mem_wdata} <= {1'b1, a, d};
		@(posedge clk);
		host_mem_we <= 1'b0;
	endtask : mw

	// ------
	// Scenarios
	// ------
	task automatic t_invert();
		op(FN_BIT_INVERT, 1'b1, 16'h0, 16'h0, 16'h9999, 3'b000);
		chk(st(), {16'h6666, 3'b000});
		op(FN_BIT_INVERT, 1'b1, 16'h0, 16'h0, 16'h9999, 3'b000);
		chk(st(), {16'h6666, 3'b000});
		op(FN_BIT_INVERT, 1'b1, 16'h0, 16'h0, 16'hffff, 3'b000);
		chk(st(), {16'h0000, 3'b010});
	endtask : t_invert

	task automatic t_acc_off();
		op(FN_BCD_ADD, 1'b0, 16'h0001, 16'h0001, 16'h0, 3'b000);
		chk(st(), {16'h0000, 3'b010});
		op(6'h20, 1'b1, 16'h0001, 16'h0001, 16'h0, 3'b000);
		chk(st(), {16'h0000, 3'b010});
	endtask : t_acc_off

	task automatic t_add();
		pl(1'b1, 1'b0);
		op(FN_BCD_ADD, 1'b1, 16'h1234, 16'h8766, 16'h0, 3'b000);
		chk(st(), {16'h0000, 3'b110});
		op(FN_BCD_ADD, 1'b1, 16'h0001, 16'h0002, 16'h0, 3'b000);
		chk(st(), {16'h0004, 3'b000});
	endtask : t_add

	task automatic t_sub();
		pl(1'b1, 1'b0);
		op(FN_BCD_SUB, 1'b1, 16'h0000, 16'h0001, 16'h0, 3'b000);
		chk(st(), {16'h9999, 3'b100});
		op(FN_BCD_SUB, 1'b1, 16'h0003, 16'h0001, 16'h0, 3'b000);
		chk(st(), {16'h0001, 3'b000});
		op(FN_BCD_SUB, 1'b1, 16'h2500, 16'h2500, 16'h0, 3'b000);
		chk(st(), {16'h0000, 3'b010});
	endtask : t_sub

	task automatic t_bad();
		op(FN_BCD_ADD, 1'b1, 16'h12a4, 16'h0001, 16'h0, 3'b000);
		chk(st(), {16'h0000, 3'b011});
		pl(1'b0, 1'b1);
		op(FN_BCD_SUB, 1'b1, 16'h0001, 16'h00f0, 16'h0, 3'b000);
		chk(st(), {16'h0000, 3'b011});
		pl(1'b0, 1'b1);
	endtask : t_bad

	task automatic t_ind();
		mw(9'd200, 16'h0042);
		mw(9'd10, 16'h1234);
		mw(9'd511, 16'h0001);
		op(FN_BCD_ADD, 1'b1, 16'h0200, 16'h0008, 16'h0, 3'b100);
		chk(st(), {16'h0050, 3'b000});
		op(FN_BCD_ADD, 1'b1, 16'h0511, 16'h0001, 16'h0, 3'b100);
		chk(st(), {16'h0002, 3'b000});
		op(FN_BIT_INVERT, 1'b1, 16'h0, 16'h0, 16'h0010, 3'b001);
		@(posedge clk);
		host_mem_addr <= 9'd10;
		repeat (2) @(posedge clk);
		#1;
		chk({host_mem_rdata, 3'b000}, {16'hedcb, 3'b000});
		op(FN_BCD_ADD, 1'b1, 16'h0512, 16'h0001, 16'h0, 3'b100);
		chk(st(), {16'h0002, 3'b001});
		pl(1'b0, 1'b1);
		op(FN_BCD_ADD, 1'b1, 16'h00a0, 16'h0001, 16'h0, 3'b100);
		chk(st(), {16'h0002, 3'b001});
		pl(1'b0, 1'b1);
		op(FN_BCD_ADD, 1'b1, 16'h0005, 16'h0200, 16'h0300, 3'b011);
		chk(st(), {16'h0002, 3'b000});
		@(posedge clk);
		host_mem_addr <= 9'h12c;
		repeat (2) @(posedge clk);
		#1;
		chk({host_mem_rdata, 3'b000}, {16'h0047, 3'b000});
	endtask : t_ind

	task automatic end_sim();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// ------
	// Clock, reset and timeout
	// ------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// The whole run needs well under a thousand cycles; the ceiling leaves room.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			end_sim();
		end
	end

	initial begin
		{sys_rst, start, acc_bit, src1_ind, src2_ind, dst_ind} = 6'h20;
		{carry_clear_op, error_clear, host_mem_we, function_code} = 9'h000;
		{host_mem_addr, src1_word, src2_word, dst_word, host_mem_wdata} = 73'h0;
		n_fail = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_invert();
		t_acc_off();
		t_add();
		t_sub();
		t_bad();
		t_ind();
		end_sim();
	end
endmodule : bcd_add_sub_complement_unit_bench
`default_nettype wire

// ==== testbench/bcu_seq_model.sv ====
/* Instruction sequencer model: raises a request, holds it until taken,
 * and stores a direct result. Assumes one clock shared with the unit. */
`timescale 1ns/100ps
`default_nettype none

module bcu_seq_model (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        start,
	input  wire logic        req_ready,
	input  wire logic        res_write,
	input  wire logic [15:0] res_word,
	output logic             req_valid,
	output logic      [15:0] stored
);
	// One start is one scan; a held accumulator means the bench starts again.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_valid <= 1'b0;
			stored <= 16'h0000;
		end else begin
			if (start) begin
				req_valid <= 1'b1;
			end else if (req_ready) begin
				req_valid <= 1'b0;
			end
			if (res_write) begin
				stored <= res_word;
			end
		end
	end
endmodule : bcu_seq_model
`default_nettype wire

// ==== testbench/bcu_unit_sva.sv ====
/* Assertions on the request, result and flag ports of the word unit.
 * Assumes it is bound into bcu_unit and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none

module bcu_unit_chk
	import bcu_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [5:0]  function_code,
	input wire logic        acc_bit,
	input wire logic        carry_clear_op,
	input wire logic [15:0] res_word,
	input wire logic        res_write,
	input wire logic        done,
	input wire logic        skipped,
	input wire logic        carry_flag,
	input wire logic        zero_flag,
	input wire logic        error_flag
);
	logic take;
	logic known;
	assign take = req_valid && req_ready;
	assign known = function_code inside {FN_BIT_INVERT, FN_BCD_ADD, FN_BCD_SUB};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	skip_acc_a: assert property (take && !acc_bit |=> done && skipped && !res_write)
		else $error("accumulator off but request not skipped");
	flag_hold_a: assert property (take && !acc_bit |=> $stable(zero_flag) && $stable(error_flag))
		else $error("flags moved on a skipped request");
	busy_ready_a: assert property (take && acc_bit && known |=> !req_ready)
		else $error("ready stayed high while executing");
	done_bound_a: assert property (take |-> ##[1:8] done)
		else $error("request not finished in time");
	write_done_a: assert property (res_write |-> done && !skipped)
		else $error("result written without a finished request");
	zero_flag_a: assert property (res_write |-> zero_flag == (res_word == 16'h0000))
		else $error("zero flag disagrees with result");
	err_skip_a: assert property ($rose(error_flag) |-> done && skipped)
		else $error("error raised without skipping");
	res_keep_a: assert property (skipped |-> $stable(res_word))
		else $error("result changed on a skipped request");
	carry_clr_a: assert property (carry_clear_op && req_ready && !req_valid |=> !carry_flag)
		else $error("carry not cleared");

	cover property (take && function_code == FN_BCD_ADD);
	cover property (res_write && carry_flag);
	cover property ($rose(error_flag));
	cover property (done && !skipped && !res_write);
endmodule : bcu_unit_chk

bind bcu_unit bcu_unit_chk i_chk (.*);
`default_nettype wire
